// file: rtl/svm_params.svh
// Offsets, fields, reset values and timing counts of the valve mode sequencer
`ifndef SVM_PARAMS_SVH
`define SVM_PARAMS_SVH
`define SVM_REG_CTRL 8'h00
`define SVM_REG_DEMAND 8'h04
`define SVM_REG_STATUS 8'h08
`define SVM_REG_POS 8'h0C
`define SVM_REG_COIL 8'h10
`define SVM_REG_CAL_ZERO 8'h14
`define SVM_REG_CAL_TOP 8'h18
`define SVM_REG_GAIN 8'h1C
`define SVM_REG_WDOG 8'h20
`define SVM_REG_RATE 8'h24
`define SVM_CTRL_TRACK 0
`define SVM_CTRL_CAL_REQ 1
`define SVM_CTRL_CAL_ZERO 2
`define SVM_CTRL_CAL_TOP 3
`define SVM_CTRL_CAL_NULL 4
`define SVM_CTRL_CAL_FULL 5
`define SVM_CTRL_CLR_RESTRICT 6
`define SVM_WDOG_RESET 32'h000F4240
`define SVM_RATE_RESET 16'h0010
`define SVM_GAIN_RESET 16'h0080
`define SVM_GAIN_MIN 16'h0004
`define SVM_GAIN_MAX 16'h0FFF
`define SVM_DAC_ZERO 16'h8000
`define SVM_FB_LO 16'hC1EC
`define SVM_FB_HI 16'hF334
`define SVM_FB_TARGET 16'hFDC3
`define SVM_FB_TOP 16'h4000
`define SVM_CLK_HZ 10000000
`define SVM_LOCAL_BAUD 19200
`define SVM_LINK_BAUD 9600
`define SVM_LOCAL_DIV (`SVM_CLK_HZ / `SVM_LOCAL_BAUD)
`define SVM_LINK_DIV (`SVM_CLK_HZ / `SVM_LINK_BAUD)
`endif

// file: rtl/svm_pkg.sv
// Types of the valve mode sequencer
package svm_pkg;
  typedef enum logic [3:0] {
    MODE_START = 4'h0,
    MODE_FACT_CFG = 4'h1,
    MODE_FACT_TEST = 4'h2,
    MODE_LOCAL = 4'h3,
    MODE_NORMAL = 4'h4,
    MODE_CAL_LOW = 4'h5,
    MODE_CAL_HIGH = 4'h6,
    MODE_CAL_BACK = 4'h7,
    MODE_CAL_STORE = 4'h8,
    MODE_CAL_NULL = 4'h9
  } mode_t;
  typedef struct packed {
    logic logic_load_ok;
    logic prog_sum_ok;
    logic param_sum_ok;
    logic ram_ok;
    logic dac_readback_ok;
    logic uart_scratch_ok;
    logic shmem_readback_ok;
  } start_checks_t;
  typedef struct packed {
    logic [15:0] zero;
    logic [15:0] top;
    logic [15:0] gain;
  } cal_set_t;
endpackage

// file: rtl/svm_cal_store.sv
// Calibration store, reloaded with defaults at reset: two positions and gain with checksum
`timescale 1ns/1ps
`include "svm_params.svh"
module svm_cal_store (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write side
  input wire logic wr_en,
  input wire svm_pkg::cal_set_t wr_data,
  // Read side
  output svm_pkg::cal_set_t rd_data,
  output logic [15:0] checksum
);
  svm_pkg::cal_set_t mem_ff;
  logic [15:0] sum_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mem_ff <= {16'hC000, 16'h4000, `SVM_GAIN_RESET};
    end
    else if (wr_en)
    begin
      mem_ff <= wr_data;
    end
  end

  // Sum covers only these three words, other constants are not refreshed
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sum_ff <= 16'h0000;
    end
    else if (wr_en)
    begin
      sum_ff <= wr_data.zero + wr_data.top + wr_data.gain;
    end
  end

  assign rd_data = mem_ff;
  assign checksum = sum_ff;
endmodule

// file: rtl/svm_uart_tx.sv
// Serial transmitter, 8 data bits, one stop bit, no parity
`timescale 1ns/1ps
`include "svm_params.svh"
module svm_uart_tx #(
  parameter int DIV = `SVM_LOCAL_DIV
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Byte in
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy,
  // Line
  output logic txd
);
  logic [15:0] cnt_ff;
  logic [3:0] bit_ff;
  logic [9:0] sh_ff;
  logic busy_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_ff <= 1'b0;
      cnt_ff <= 16'h0000;
      bit_ff <= 4'h0;
      sh_ff <= 10'h3FF;
    end
    else if (!busy_ff)
    begin
      if (start)
      begin
        busy_ff <= 1'b1;
        sh_ff <= {1'b1, data, 1'b0};
        cnt_ff <= 16'(DIV - 1);
        bit_ff <= 4'h0;
      end
    end
    else if (cnt_ff == 16'h0000)
    begin
      cnt_ff <= 16'(DIV - 1);
      sh_ff <= {1'b1, sh_ff[9:1]};
      bit_ff <= bit_ff + 4'h1;
      if (bit_ff == 4'h9)
      begin
        busy_ff <= 1'b0;
      end
    end
    else
    begin
      cnt_ff <= cnt_ff - 16'h0001;
    end
  end

  assign busy = busy_ff;
  assign txd = sh_ff[0];
endmodule

// file: rtl/svm_top.sv
// Servo valve mode sequencer with AXI4-Lite register slave
// Operation
// - Supply off, converter idle until first pattern
// - Enable supply, then write zero-volt code
// - Leave start for local only when all checks pass
// - Factory enable pin selects factory config, test request selects factory test
// - Target demand loaded from feedback first
// - Local set point from link or serial
// - Watchdog expiry drops normal to local
// - Local to normal needs refresh and tracking
// - Local runs loop, publishes, honours raise/lower
// - Normal takes controller demand, ignores raise/lower
// - Calibrate request bit starts travel sequence
// - Feedback from stored values, programmable rate
// - Calibrate exit skips bumpless condition
// - Hot zero sets closed value only
// - Hot top sets open value only
// - Null cal stops at electrical null
// - Closed end gain window, bounded gain
// - Inside window retarget gain, go open
// - Open end only lowers gain, records
// - Back to closed, record, store all
// - After store clear restriction flag
// - Local serial 19200 8N1, prints status in calibration modes
// - Checksum covers only positions and gain
// - Station link at 9600 baud
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "svm_params.svh"
module svm_top #(
  parameter int WDOG_CYCLES = `SVM_WDOG_RESET
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Start checks and straps
  input wire svm_pkg::start_checks_t checks,
  input wire logic checks_done,
  input wire logic factory_enable_pin,
  input wire logic factory_test_req,
  // Valve feedback and drive
  input wire logic [15:0] feedback,
  output logic servo_supply_en,
  output logic dac_enable,
  output logic [15:0] dac_code,
  output logic [15:0] demod_gain,
  // Station link and local serial set point
  input wire logic station_link_raise,
  input wire logic station_link_lower,
  input wire logic local_sp_valid,
  input wire logic [15:0] local_sp,
  output logic station_link_tx,
  output logic local_serial_transmit,
  // Mode
  output svm_pkg::mode_t mode
);
  svm_pkg::mode_t mode_ff;
  svm_pkg::cal_set_t cal_rd;
  logic [15:0] cal_sum;
  logic [15:0] target_ff, ctl_demand_ff, gain_ff, zero_ff, top_ff, rate_ff, dac_ff;
  logic [31:0] wdog_lim_ff, wdog_cnt_ff;
  logic [6:0] ctrl_ff;
  logic supply_ff, dac_en_ff, start_fail_ff, restrict_ff, demand_wr;
  logic aw_ff, w_ff, bv_ff, rv_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic store_wr, tx_start, tx_busy, link_busy;
  logic [7:0] tx_byte;

  function automatic logic sgt(input logic [15:0] a, input logic [15:0] b);
    sgt = $signed(a) > $signed(b);
  endfunction

  function automatic logic [15:0] step_to(input logic [15:0] cur, input logic [15:0] dst, input logic [15:0] r);
    if (sgt(dst, cur))
      step_to = (16'(dst - cur) > r) ? 16'(cur + r) : dst;
    else
      step_to = (16'(cur - dst) > r) ? 16'(cur - r) : dst;
  endfunction

  // Signed ratio, so a negative closed end still scales the right way
  function automatic logic [15:0] gain_fit(input logic signed [15:0] g, input logic signed [15:0] fb);
    logic signed [31:0] q;
    q = g * $signed(`SVM_FB_TARGET) / fb;
    if (q < $signed(32'(`SVM_GAIN_MIN)))
      gain_fit = `SVM_GAIN_MIN;
    else if (q > $signed(32'(`SVM_GAIN_MAX)))
      gain_fit = `SVM_GAIN_MAX;
    else
      gain_fit = q[15:0];
  endfunction

  // AXI write: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      bv_ff <= 1'b0;
      bresp_ff <= 2'h0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_ff && !bv_ff)
      begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_ff && !bv_ff)
      begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (aw_ff && w_ff)
      begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bv_ff <= 1'b1;
        bresp_ff <= (awaddr_ff <= `SVM_REG_RATE && awaddr_ff[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end
      if (bv_ff && s_axi_bready)
      begin
        bv_ff <= 1'b0;
      end
    end
  end

  wire wr_go = aw_ff && w_ff;
  assign demand_wr = wr_go && awaddr_ff == `SVM_REG_DEMAND;

  // Software registers; byte strobes ignored beyond all-or-nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff <= 7'h00;
      ctl_demand_ff <= 16'h0000;
      wdog_lim_ff <= 32'(WDOG_CYCLES);
      rate_ff <= `SVM_RATE_RESET;
    end
    else if (wr_go && wstrb_ff != 4'h0)
    begin
      case (awaddr_ff)
        `SVM_REG_CTRL: ctrl_ff <= wdata_ff[6:0];
        `SVM_REG_DEMAND: ctl_demand_ff <= wdata_ff[15:0];
        `SVM_REG_WDOG: wdog_lim_ff <= wdata_ff;
        `SVM_REG_RATE: rate_ff <= wdata_ff[15:0];
        default: ;
      endcase
    end
    else if (mode_ff != svm_pkg::MODE_LOCAL)
    begin
      ctrl_ff[`SVM_CTRL_CAL_REQ] <= 1'b0;
    end
  end

  // AXI read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rv_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= 2'h0;
    end
    else if (rv_ff)
    begin
      if (s_axi_rready)
        rv_ff <= 1'b0;
    end
    else if (s_axi_arvalid)
    begin
      rv_ff <= 1'b1;
      rresp_ff <= 2'h0;
      case (s_axi_araddr)
        `SVM_REG_CTRL: rdata_ff <= {25'h0, ctrl_ff};
        `SVM_REG_DEMAND: rdata_ff <= {16'h0, ctl_demand_ff};
        `SVM_REG_STATUS: rdata_ff <= {16'h0, cal_sum[7:0], 1'b0, restrict_ff, start_fail_ff, 1'b0, mode_ff};
        `SVM_REG_POS: rdata_ff <= {16'h0, feedback};
        `SVM_REG_COIL: rdata_ff <= {16'h0, dac_ff};
        `SVM_REG_CAL_ZERO: rdata_ff <= {16'h0, cal_rd.zero};
        `SVM_REG_CAL_TOP: rdata_ff <= {16'h0, cal_rd.top};
        `SVM_REG_GAIN: rdata_ff <= {16'h0, cal_rd.gain};
        `SVM_REG_WDOG: rdata_ff <= wdog_lim_ff;
        `SVM_REG_RATE: rdata_ff <= {16'h0, rate_ff};
        default:
        begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= 2'h2;
        end
      endcase
    end
  end

  // Update watchdog, restarted by every demand write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wdog_cnt_ff <= 32'h00000000;
    else if (demand_wr)
      wdog_cnt_ff <= 32'h00000000;
    else if (wdog_cnt_ff < wdog_lim_ff)
      wdog_cnt_ff <= wdog_cnt_ff + 32'h00000001;
  end

  wire wdog_ok = wdog_cnt_ff < wdog_lim_ff;
  // Travel done once the ramp reaches the stage end point
  wire [15:0] cal_dest = (mode_ff == svm_pkg::MODE_CAL_HIGH) ? cal_rd.top : cal_rd.zero;
  wire at_target = target_ff == cal_dest;

  // Mode sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_ff <= svm_pkg::MODE_START;
    else
      case (mode_ff)
        svm_pkg::MODE_START:
          if (factory_enable_pin)
            mode_ff <= svm_pkg::MODE_FACT_CFG;
          else if (factory_test_req)
            mode_ff <= svm_pkg::MODE_FACT_TEST;
          else if (checks_done && &checks && dac_en_ff)
            mode_ff <= svm_pkg::MODE_LOCAL;
        svm_pkg::MODE_LOCAL:
          if (ctrl_ff[`SVM_CTRL_CAL_REQ])
            mode_ff <= ctrl_ff[`SVM_CTRL_CAL_TOP] ? svm_pkg::MODE_CAL_HIGH :
                       ctrl_ff[`SVM_CTRL_CAL_NULL] && !ctrl_ff[`SVM_CTRL_CAL_FULL] ?
                       svm_pkg::MODE_CAL_NULL : svm_pkg::MODE_CAL_LOW;
          else if (wdog_ok && ctrl_ff[`SVM_CTRL_TRACK] && !restrict_ff)
            mode_ff <= svm_pkg::MODE_NORMAL;
        svm_pkg::MODE_NORMAL:
          if (!wdog_ok)
            mode_ff <= svm_pkg::MODE_LOCAL;
        svm_pkg::MODE_CAL_LOW:
          if (ctrl_ff[`SVM_CTRL_CAL_NULL] && feedback == 16'h0000)
            mode_ff <= svm_pkg::MODE_CAL_STORE;
          else if (at_target && ctrl_ff[`SVM_CTRL_CAL_ZERO])
            mode_ff <= svm_pkg::MODE_CAL_STORE;
          else if (at_target && !sgt(`SVM_FB_LO, feedback) && !sgt(feedback, `SVM_FB_HI))
            mode_ff <= svm_pkg::MODE_CAL_HIGH;
        svm_pkg::MODE_CAL_HIGH:
          if (at_target && !sgt(feedback, `SVM_FB_TOP))
            mode_ff <= ctrl_ff[`SVM_CTRL_CAL_TOP] ? svm_pkg::MODE_CAL_STORE : svm_pkg::MODE_CAL_BACK;
        svm_pkg::MODE_CAL_BACK:
          if (at_target)
            mode_ff <= svm_pkg::MODE_CAL_STORE;
        svm_pkg::MODE_CAL_NULL:
          if (feedback == 16'h0000)
            mode_ff <= svm_pkg::MODE_CAL_STORE;
        svm_pkg::MODE_CAL_STORE:
          mode_ff <= svm_pkg::MODE_LOCAL;
        svm_pkg::MODE_FACT_CFG, svm_pkg::MODE_FACT_TEST:
          mode_ff <= mode_ff;
        default:
          mode_ff <= svm_pkg::MODE_START;
      endcase
  end

  // Supply first, then zero code arms the converter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      supply_ff <= 1'b0;
      dac_en_ff <= 1'b0;
    end
    else
    begin
      supply_ff <= 1'b1;
      if (supply_ff)
        dac_en_ff <= 1'b1;
    end
  end

  // Crude proportional drive; loop tuning lives elsewhere
  always_ff @(posedge aclk)
  begin
    if (!aresetn || mode_ff == svm_pkg::MODE_START || !dac_en_ff)
      dac_ff <= `SVM_DAC_ZERO;
    else
      dac_ff <= 16'(`SVM_DAC_ZERO + 16'(target_ff - feedback));
  end

  // Target demand per mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      target_ff <= 16'h0000;
    else
      case (mode_ff)
        svm_pkg::MODE_START: target_ff <= feedback;
        svm_pkg::MODE_LOCAL:
          if (local_sp_valid)
            target_ff <= local_sp;
          else if (station_link_raise)
            target_ff <= 16'(target_ff + rate_ff);
          else if (station_link_lower)
            target_ff <= 16'(target_ff - rate_ff);
        svm_pkg::MODE_NORMAL: target_ff <= ctl_demand_ff;
        svm_pkg::MODE_CAL_LOW, svm_pkg::MODE_CAL_BACK:
          target_ff <= step_to(target_ff, cal_rd.zero, rate_ff);
        svm_pkg::MODE_CAL_HIGH: target_ff <= step_to(target_ff, cal_rd.top, rate_ff);
        svm_pkg::MODE_CAL_NULL: target_ff <= step_to(target_ff, 16'h0000, rate_ff);
        default: target_ff <= target_ff;
      endcase
  end

  // Gain and recorded positions
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gain_ff <= `SVM_GAIN_RESET;
      zero_ff <= 16'h0000;
      top_ff <= 16'h0000;
    end
    else if (mode_ff == svm_pkg::MODE_LOCAL)
    begin
      gain_ff <= cal_rd.gain;
      zero_ff <= cal_rd.zero;
      top_ff <= cal_rd.top;
    end
    else if (mode_ff == svm_pkg::MODE_CAL_LOW && at_target)
    begin
      zero_ff <= feedback;
      if (!ctrl_ff[`SVM_CTRL_CAL_ZERO])
      begin
        if (sgt(`SVM_FB_LO, feedback) && gain_ff > `SVM_GAIN_MIN)
          gain_ff <= gain_ff - 16'h0001;
        else if (sgt(feedback, `SVM_FB_HI) && gain_ff < `SVM_GAIN_MAX)
          gain_ff <= gain_ff + 16'h0001;
        else if (feedback != 16'h0000)
          gain_ff <= gain_fit(gain_ff, feedback);
      end
    end
    else if (mode_ff == svm_pkg::MODE_CAL_HIGH && at_target)
    begin
      if (sgt(feedback, `SVM_FB_TOP))
      begin
        if (!ctrl_ff[`SVM_CTRL_CAL_TOP] && gain_ff > `SVM_GAIN_MIN)
          gain_ff <= gain_ff - 16'h0001;
      end
      else
        top_ff <= feedback;
    end
    else if (mode_ff == svm_pkg::MODE_CAL_BACK && at_target)
      zero_ff <= feedback;
  end

  assign store_wr = mode_ff == svm_pkg::MODE_CAL_STORE;

  // Restriction and start failure flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      restrict_ff <= 1'b0;
      start_fail_ff <= 1'b0;
    end
    else
    begin
      if (ctrl_ff[`SVM_CTRL_CAL_REQ] && mode_ff == svm_pkg::MODE_LOCAL)
        restrict_ff <= 1'b1;
      else if (store_wr)
        restrict_ff <= 1'b0;
      if (mode_ff == svm_pkg::MODE_START && checks_done && !(&checks))
        start_fail_ff <= 1'b1;
    end
  end

  // Status byte sent whenever the transmitter is idle in a calibration mode
  assign tx_start = !tx_busy && mode_ff >= svm_pkg::MODE_CAL_LOW;
  assign tx_byte = {4'h3, mode_ff};

  svm_cal_store u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(store_wr),
    .wr_data({zero_ff, top_ff, gain_ff}),
    .rd_data(cal_rd),
    .checksum(cal_sum)
  );

  svm_uart_tx #(.DIV(`SVM_LOCAL_DIV)) u_local (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(tx_start),
    .data(tx_byte),
    .busy(tx_busy),
    .txd(local_serial_transmit)
  );

  // Station link publishes high position byte
  svm_uart_tx #(.DIV(`SVM_LINK_DIV)) u_link (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(!link_busy && mode_ff != svm_pkg::MODE_START),
    .data(feedback[15:8]),
    .busy(link_busy),
    .txd(station_link_tx)
  );

  assign s_axi_awready = !aw_ff && !bv_ff;
  assign s_axi_wready = !w_ff && !bv_ff;
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rv_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign servo_supply_en = supply_ff;
  assign dac_enable = dac_en_ff;
  assign dac_code = dac_ff;
  assign demod_gain = gain_ff;
  assign mode = mode_ff;
endmodule

// file: verif/svm_top_assertions.sv
// Port checks for the valve mode sequencer
`timescale 1ns/1ps
`include "svm_params.svh"
module svm_top_checker #(
  parameter int WDOG_CYCLES = `SVM_WDOG_RESET
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Demand write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  // Straps
  input wire svm_pkg::start_checks_t checks,
  input wire logic factory_enable_pin,
  // Drive and mode
  input wire logic servo_supply_en,
  input wire logic dac_enable,
  input wire logic [15:0] dac_code,
  input wire logic [15:0] demod_gain,
  input wire svm_pkg::mode_t mode
);
  logic [31:0] wd_cnt_ff;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Saturates, so a long idle never wraps into a false refresh
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (s_axi_awvalid && s_axi_awready && s_axi_awaddr == `SVM_REG_DEMAND))
      wd_cnt_ff <= 32'h0;
    else if (wd_cnt_ff != 32'hFFFFFFFF)
      wd_cnt_ff <= wd_cnt_ff + 32'h1;
  end
  power_up_off_a: assert property ($rose(aresetn) |-> !servo_supply_en && !dac_enable)
    else $error("drive active at reset release");
  supply_first_a: assert property ($rose(dac_enable) |-> $past(servo_supply_en))
    else $error("converter enabled before supply");
  zero_code_a: assert property ($rose(dac_enable) |-> dac_code == `SVM_DAC_ZERO)
    else $error("first converter code not zero volts");
  start_exit_a: assert property (mode == svm_pkg::MODE_LOCAL && $past(mode) == svm_pkg::MODE_START
    |-> $past(checks) == 7'h7F) else $error("start left with a failed check");
  fact_cfg_a: assert property ($past(mode) == svm_pkg::MODE_START && mode != svm_pkg::MODE_START
    && $past(factory_enable_pin) |-> mode == svm_pkg::MODE_FACT_CFG) else $error("factory pin ignored");
  normal_wdog_a: assert property (mode == svm_pkg::MODE_NORMAL |-> wd_cnt_ff <= 32'(WDOG_CYCLES + 8))
    else $error("normal kept after watchdog expiry");
  gain_range_a: assert property (demod_gain >= `SVM_GAIN_MIN && demod_gain <= `SVM_GAIN_MAX)
    else $error("gain out of range");
  open_gain_a: assert property (mode == svm_pkg::MODE_CAL_HIGH && $past(mode) == svm_pkg::MODE_CAL_HIGH
    |-> demod_gain <= $past(demod_gain)) else $error("gain raised at open end");
  cover property (mode == svm_pkg::MODE_NORMAL);
  cover property (mode == svm_pkg::MODE_CAL_STORE);
  cover property (mode == svm_pkg::MODE_FACT_TEST);
endmodule

bind svm_top svm_top_checker #(.WDOG_CYCLES(WDOG_CYCLES)) i_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .checks, .factory_enable_pin, .servo_supply_en, .dac_enable, .dac_code, .demod_gain, .mode);

// file: verif/svm_ctrl_model.sv
// Supervisory controller model, master of the shared register bus
`timescale 1ns/1ps
module svm_ctrl_model (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_wstrb <= 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!(aw_ok && w_ok));
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= addr;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// file: verif/test_servo_valve_mode_sequencer.sv
// Self-checking bench for the valve mode sequencer
`timescale 1ns/1ps
`include "svm_params.svh"
module test_servo_valve_mode_sequencer;
  typedef struct {
    bit we;
    logic [7:0] addr;
    logic [31:0] data;
    logic [31:0] mask;
    logic [1:0] resp;
  } row_t;
  // Short watchdog keeps expiry within a few dozen cycles
  localparam int WDOG = 50;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  svm_pkg::start_checks_t checks = 7'h7B;
  logic checks_done = 1'b1;
  logic factory_enable_pin = 1'b0;
  logic factory_test_req = 1'b0;
  logic [15:0] feedback = 16'hE000;
  logic [15:0] fb_low = 16'hE000;
  logic servo_supply_en, dac_enable, station_link_tx, local_serial_transmit;
  logic [15:0] dac_code, demod_gain;
  svm_pkg::mode_t mode;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  row_t rows [6] = '{'{0, `SVM_REG_RATE, 32'h10, 32'hFFFF, 2'h0}, '{1, `SVM_REG_RATE, 32'h25, 32'h0, 2'h0},
    '{0, `SVM_REG_RATE, 32'h25, 32'hFFFF, 2'h0}, '{0, `SVM_REG_STATUS, 32'h3, 32'h7F, 2'h0},
    '{0, 8'h28, 32'h0, 32'h0, 2'h2}, '{1, 8'h40, 32'h1, 32'h0, 2'h2}};

  svm_top #(.WDOG_CYCLES(WDOG)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .checks, .checks_done, .factory_enable_pin, .factory_test_req, .feedback, .servo_supply_en, .dac_enable,
    .dac_code, .demod_gain, .station_link_raise(1'b0), .station_link_lower(1'b0), .local_sp_valid(1'b0),
    .local_sp(16'h0000), .station_link_tx, .local_serial_transmit, .mode);
  svm_ctrl_model i_ctrl (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  always #50 aclk = ~aclk;
  // Valve stand-in: open end reads just inside the upper limit
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    feedback <= (mode == svm_pkg::MODE_CAL_HIGH) ? 16'h3000 : fb_low;
    if (cycles == 60000)
    begin
      failures++;
      results();
    end
  end

  task automatic results();
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic wait_mode(input svm_pkg::mode_t m, input int lim);
    int i;
    i = 0;
    while (mode !== m && i < lim)
    begin
      @(posedge aclk);
      i++;
    end
    chk("mode", 32'(m), 32'(mode));
  endtask
  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic [31:0] mask);
    i_ctrl.rd(addr, rdat, resp);
    chk("rdata", exp, rdat & mask);
  endtask

  initial
  begin
    do_reset();
    chk("power_up", 32'h00008000, {14'h0, servo_supply_en, dac_enable, dac_code});
    chk("tx_idle", 32'h3, {30'h0, station_link_tx, local_serial_transmit});
    repeat (30) @(posedge aclk);
    chk("drive_on", 32'h3, {30'h0, servo_supply_en, dac_enable});
    chk("mode", 32'(svm_pkg::MODE_START), 32'(mode));
    rd_chk(`SVM_REG_STATUS, 32'h20, 32'h2F);
    checks <= 7'h7F;
    for (int k = 0; k < 2; k++)
    begin
      factory_enable_pin <= (k == 0);
      factory_test_req <= (k == 1);
      do_reset();
      wait_mode(k ? svm_pkg::MODE_FACT_TEST : svm_pkg::MODE_FACT_CFG, 40);
    end
    factory_enable_pin <= 1'b0;
    factory_test_req <= 1'b0;
    do_reset();
    wait_mode(svm_pkg::MODE_LOCAL, 40);
    foreach (rows[i])
    begin
      if (rows[i].we)
        i_ctrl.wr(rows[i].addr, rows[i].data, resp);
      else
        rd_chk(rows[i].addr, rows[i].data, rows[i].mask);
      chk("resp", 32'(rows[i].resp), 32'(resp));
    end
    // Demand refreshed but no tracking: must stay local
    i_ctrl.wr(`SVM_REG_DEMAND, 32'h1000, resp);
    repeat (10) @(posedge aclk);
    chk("mode", 32'(svm_pkg::MODE_LOCAL), 32'(mode));
    i_ctrl.wr(`SVM_REG_CTRL, 32'h1, resp);
    repeat (5)
    begin
      i_ctrl.wr(`SVM_REG_DEMAND, 32'h1000, resp);
      repeat (20) @(posedge aclk);
    end
    chk("mode", 32'(svm_pkg::MODE_NORMAL), 32'(mode));
    wait_mode(svm_pkg::MODE_LOCAL, WDOG + 20);
    i_ctrl.wr(`SVM_REG_CTRL, 32'h22, resp);
    wait_mode(svm_pkg::MODE_CAL_LOW, 20);
    wait_mode(svm_pkg::MODE_LOCAL, 20000);
    rd_chk(`SVM_REG_CAL_TOP, 32'h3000, 32'hFFFF);
    rd_chk(`SVM_REG_CAL_ZERO, 32'hE000, 32'hFFFF);
    rd_chk(`SVM_REG_STATUS, 32'h3, 32'h4F);
    rd_chk(`SVM_REG_GAIN, 32'h8, 32'hFFFF);
    // Hot zero moves only the closed-end value
    fb_low <= 16'hD000;
    i_ctrl.wr(`SVM_REG_CTRL, 32'h06, resp);
    repeat (4) @(posedge aclk);
    wait_mode(svm_pkg::MODE_LOCAL, 20000);
    rd_chk(`SVM_REG_CAL_ZERO, 32'hD000, 32'hFFFF);
    rd_chk(`SVM_REG_CAL_TOP, 32'h3000, 32'hFFFF);
    rd_chk(`SVM_REG_GAIN, 32'h8, 32'hFFFF);
    rd_chk(`SVM_REG_POS, 32'hD000, 32'hFFFF);
    results();
  end
endmodule
